/* cache_bus_pkg.sv */
package cache_bus_pkg;

	// alternate address spaces
	localparam logic [7:0]  ASI_CONTROL    = 8'h01;
	localparam logic [7:0]  ASI_ITAG_LOCK  = 8'h02;
	localparam logic [7:0]  ASI_DTAG_LOCK  = 8'h03;
	localparam logic [7:0]  ASI_ITAG       = 8'h0C;
	localparam logic [7:0]  ASI_IDATA      = 8'h0D;

	// control space offsets; the two invalidate offsets lie in the itag space
	localparam logic [31:0] OFS_CACHE_BUS  = 32'h00000000;
	localparam logic [31:0] OFS_AUTO_LOCK  = 32'h00000004;
	localparam logic [31:0] OFS_LOCK_SAVE  = 32'h00000008;
	localparam logic [31:0] OFS_RESTORE    = 32'h00000010;
	localparam logic [31:0] OFS_BURST      = 32'h00000020;
	localparam logic [31:0] OFS_CS_ENABLE  = 32'h00000080;
	localparam logic [31:0] OFS_RANGE_BASE = 32'h00000124;
	localparam logic [31:0] OFS_MASK_BASE  = 32'h00000140;
	localparam logic [31:0] OFS_WIDTH      = 32'h0000016C;
	localparam logic [31:0] OFS_REFRESH    = 32'h00000174;
	localparam logic [31:0] OFS_RELOAD     = 32'h00000178;
	localparam logic [31:0] OFS_VERSION    = 32'h00000200;
	localparam logic [31:0] OFS_SLEEP      = 32'h00000204;
	localparam logic [31:0] OFS_INVAL_STD  = 32'h00001000;
	localparam logic [31:0] OFS_INVAL_BIG  = 32'h00008000;

	// field positions
	localparam int CB_ICACHE_EN = 0;
	localparam int CB_ICACHE_LK = 1;
	localparam int CB_DCACHE_EN = 2;
	localparam int CB_DCACHE_LK = 3;
	localparam int CB_PREFETCH  = 4;
	localparam int CB_WBUF      = 5;
	localparam int CB_CACHEABLE = 7;
	localparam int CB_NC_WAIT   = 8;
	localparam int PAIR_INSTR   = 0;
	localparam int PAIR_DATA    = 1;
	localparam int SEL_LSB      = 1;
	localparam int SEL_W        = 30;
	localparam int PROBE_LSB    = 10;
	localparam int NUM_CS       = 6;
	localparam int WIDTH_W      = 24;
	localparam int HALF_W       = 16;
	localparam int MODE_BIT     = 31;
	localparam int WAY_BIT      = 31;
	localparam int SLEEP_BIT    = 0;
	localparam int TAG_SBV      = 6;
	localparam int TAG_SUP      = 5;
	localparam int TAG_LRU      = 1;
	localparam int TAG_LOCK     = 0;
	localparam int INV_VALID    = 0;
	localparam int INV_LRU_LOCK = 1;

	// reset values
	localparam logic [29:0] CS0_RANGE      = {8'h09, 22'h000000};
	localparam logic [29:0] CS0_MASK_RESET = {8'h00, 22'h00001F};
	localparam logic [15:0] REFRESH_RESET  = 16'hFFFF;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  asi;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} bus_rsp_type;

	typedef struct packed {
		logic [7:0]  asi;
		logic [31:0] addr;
	} probe_type;

	typedef struct packed {
		logic        strobe;
		logic [31:0] addr;
		logic        lock;
	} dlock_wr_type;

	typedef struct packed {
		logic               icache_en;
		logic               icache_lock;
		logic               dcache_en;
		logic               dcache_lock;
		logic               prefetch_en;
		logic               wbuf_en;
		logic               cacheable_en;
		logic [1:0]         nc_wait;
		logic [1:0]         auto_lock;
		logic [1:0]         burst_en;
		logic [5:0]         cs_en;
		logic [WIDTH_W-1:0] width_cfg;
		logic               cycle_mode;
	} ctrl_out_type;

endpackage

/* cache_bus_control_registers.sv */
// Function
// RQ1 - icache enable bit 0, dcache enable bit 2, both reset off
// RQ2 - icache global lock bit 1, dcache bit 3, reset unlocked
// RQ3 - write buffer enable at bit 5, reset off
// RQ4 - prefetch buffer enable at bit 4, reset off
// RQ5 - cacheability enable bit 7 resets off, reads back undefined
// RQ6 - non-cacheable wait field bits 9:8, reads back undefined
// RQ7 - auto entry lock enables: data bit 1, instruction bit 0
// RQ8 - save register keeps previous auto lock states
// RQ9 - burst enables data bit 1, instruction bit 0, reset off
// RQ10 - first chip select always enabled regardless of its bit
// RQ11 - chip select compares space id and address bits 31:10
// RQ12 - mask bit 0 compares, mask bit 1 ignores
// RQ13 - first select mask resets to ignore address bits 14:10
// RQ14 - 16-bit refresh count resets all ones; bit 31 test; the code has no test bit and ignores bit 31
// RQ15 - reload register: 16-bit value, cycle mode at bit 31
// RQ16 - refresh count reloads on expiry, requests recur
// RQ17 - writing 1 to sleep bit 0 enters sleep, resets 0
// RQ18 - itag lock port sets or clears one line lock per write
// RQ19 - dtag lock port forwards per-line data locks, way by bit 31
// RQ20 - itag entry has four sub-block valid bits 9:6
// RQ21 - itag bit 5 records supervisor fill
// RQ22 - itag lock bit 0; replacement bit 1 only in way one; the code keeps and returns it in way zero only
// RQ23 - invalidate bit 1 clears all replacement and lock bits
// RQ24 - invalidate bit 0 clears every valid bit
// RQ25 - icache data words read and written at four-byte stride
// RQ26 - software writes zero to reserved bits, ignores reads
// RQ27 - reads of write-only ports return zero, no side effect
module cache_bus_control_registers #(
	parameter int          LINES        = 128,
	parameter int          LINE_BYTES   = 32,
	parameter logic [31:0] INVAL_OFFSET = cache_bus_pkg::OFS_INVAL_STD,
	parameter logic [15:0] PART_VERSION = 16'h005A // arbitrary code
) (
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         ce,
	input  wire cache_bus_pkg::bus_req_type   req,
	input  wire cache_bus_pkg::probe_type     probe,
	input  wire logic                         trap_entry,
	input  wire logic                         wake,
	output cache_bus_pkg::bus_rsp_type        rsp,
	output cache_bus_pkg::ctrl_out_type       ctrl,
	output logic [cache_bus_pkg::NUM_CS-1:0]  cs_hit,
	output cache_bus_pkg::dlock_wr_type       dlock_wr,
	output logic                              refresh_req,
	output logic                              sleep_mode
);
	import cache_bus_pkg::*;

	localparam int IDX_W   = $clog2(LINES);
	localparam int OFF_W   = $clog2(LINE_BYTES);
	localparam int TAG_LSB = $clog2(LINES * LINE_BYTES);
	localparam int TAG_W   = 32 - TAG_LSB;
	localparam int WORDS   = LINES * LINE_BYTES / 4;
	localparam int WIDX_W  = $clog2(WORDS);
	localparam logic [31:0] TAG_SPAN  = 32'(LINES * LINE_BYTES);
	localparam logic [31:0] DATA_SPAN = 32'(WORDS * 4);

	if (LINE_BYTES != 32 && LINE_BYTES != 16) begin : bad_line
		$error("line size must be 16 or 32 bytes");
	end
	if (LINES < 2 || (1 << IDX_W) != LINES || TAG_LSB < 10 ||
	    TAG_LSB > 14) begin : bad_lines
		$error("line count must be a power of two, 1 to 16 KB per way");
	end
	// an invalidate port inside the tag span would alias a tag line
	if (INVAL_OFFSET < TAG_SPAN) begin : bad_inval
		$error("invalidate port must lie above the tag array");
	end

	// control state not carried by the outputs
	logic [1:0]        lock_save;
	logic [1:0]        next_lock_save;
	logic [SEL_W-1:0]  sel_range [NUM_CS];
	logic [SEL_W-1:0]  next_range [NUM_CS];
	logic [SEL_W-1:0]  sel_mask [NUM_CS];
	logic [SEL_W-1:0]  next_mask [NUM_CS];
	logic [15:0]       ref_cnt;
	logic [15:0]       next_ref_cnt;
	logic [15:0]       reload;
	logic [15:0]       next_reload;
	ctrl_out_type      next_ctrl;
	bus_rsp_type       next_rsp;
	dlock_wr_type      next_dlock;
	logic [NUM_CS-1:0] next_cs_hit;
	logic              next_refresh;
	logic              next_sleep;

	// instruction cache tag and data arrays
	logic [TAG_W-1:0]      tag_addr [2][LINES];
	logic                  tag_sup  [2][LINES];
	logic [LINES-1:0][3:0] tag_sbv  [2];
	logic [LINES-1:0]      tag_lock [2];
	logic [LINES-1:0]      tag_lru;
	logic [31:0]           idata [2][WORDS];
	logic [LINES-1:0][3:0] next_sbv   [2];
	logic [LINES-1:0]      next_tlock [2];
	logic [LINES-1:0]      next_lru;

	// decoded access
	logic              wr;
	logic              rd;
	logic              ctl_sp;
	logic              way;
	logic [IDX_W-1:0]  idx;
	logic [WIDX_W-1:0] widx;
	logic [31:0]       local_addr;
	logic [31:0]       range_off;
	logic [31:0]       mask_off;
	logic              range_hit;
	logic              mask_hit;
	logic [2:0]        sel_n;
	logic              tag_sel;
	logic              inval_sel;
	logic              data_sel;
	logic              tag_we;
	logic              lock_we;
	logic              data_we;
	logic              clr_valid;
	logic              clr_lock;
	logic [31:0]       rd_word;
	logic [29:0]       cmp;

	always_comb begin
		wr         = req.valid & req.write;
		rd         = req.valid & ~req.write;
		ctl_sp     = req.asi == ASI_CONTROL;
		way        = req.addr[WAY_BIT];
		local_addr = {1'b0, req.addr[30:0]};
		idx        = req.addr[OFF_W +: IDX_W];
		widx       = req.addr[2 +: WIDX_W];
		range_off  = req.addr - OFS_RANGE_BASE;
		mask_off   = req.addr - OFS_MASK_BASE;
		range_hit  = ctl_sp && req.addr >= OFS_RANGE_BASE &&
		             range_off < 32'(NUM_CS * 4) && range_off[1:0] == 2'b00;
		mask_hit   = ctl_sp && req.addr >= OFS_MASK_BASE &&
		             mask_off < 32'(NUM_CS * 4) && mask_off[1:0] == 2'b00;
		sel_n      = range_hit ? range_off[4:2] : mask_off[4:2];
		tag_sel    = req.asi == ASI_ITAG && local_addr < TAG_SPAN;
		inval_sel  = req.asi == ASI_ITAG && local_addr == INVAL_OFFSET;
		data_sel   = req.asi == ASI_IDATA && local_addr < DATA_SPAN;
		tag_we     = wr & tag_sel;
		lock_we    = wr & (req.asi == ASI_ITAG_LOCK) &
		             (local_addr < TAG_SPAN); // [RQ18]
		data_we    = wr & data_sel; // [RQ25]
		clr_valid  = wr & inval_sel & req.wdata[INV_VALID]; // [RQ24]
		clr_lock   = wr & inval_sel & req.wdata[INV_LRU_LOCK]; // [RQ23]
	end

	// read data; write-only ports and holes read as zero
	always_comb begin
		rd_word = '0;
		if (ctl_sp) begin
			case (req.addr)
				OFS_CACHE_BUS: begin
					// cacheable and wait-state bits deliberately not returned
					rd_word[CB_ICACHE_EN] = ctrl.icache_en; // [RQ1] [RQ5] [RQ6]
					rd_word[CB_ICACHE_LK] = ctrl.icache_lock; // [RQ2]
					rd_word[CB_DCACHE_EN] = ctrl.dcache_en;
					rd_word[CB_DCACHE_LK] = ctrl.dcache_lock;
					rd_word[CB_PREFETCH]  = ctrl.prefetch_en; // [RQ4]
					rd_word[CB_WBUF]      = ctrl.wbuf_en; // [RQ3]
				end
				OFS_AUTO_LOCK: rd_word[1:0] = ctrl.auto_lock; // [RQ7]
				OFS_LOCK_SAVE: rd_word[1:0] = lock_save; // [RQ8]
				OFS_BURST:     rd_word[1:0] = ctrl.burst_en; // [RQ9]
				OFS_CS_ENABLE: rd_word[NUM_CS-1:0] = ctrl.cs_en;
				OFS_WIDTH:     rd_word[WIDTH_W-1:0] = ctrl.width_cfg;
				OFS_REFRESH:   rd_word[HALF_W-1:0] = ref_cnt; // [RQ14]
				OFS_RELOAD: begin
					rd_word[HALF_W-1:0] = reload; // [RQ15]
					rd_word[MODE_BIT]   = ctrl.cycle_mode;
				end
				OFS_VERSION:   rd_word[HALF_W-1:0] = PART_VERSION;
				default: begin
					if (range_hit)
						rd_word[SEL_LSB +: SEL_W] = sel_range[sel_n];
					else if (mask_hit)
						rd_word[SEL_LSB +: SEL_W] = sel_mask[sel_n];
				end
			endcase
		end else if (tag_sel) begin
			rd_word[31:TAG_LSB]       = tag_addr[way][idx];
			rd_word[TAG_SBV +: 4]     = tag_sbv[way][idx]; // [RQ20]
			rd_word[TAG_SUP]          = tag_sup[way][idx]; // [RQ21]
			rd_word[TAG_LOCK]         = tag_lock[way][idx]; // [RQ22]
			rd_word[TAG_LRU]          = ~way & tag_lru[idx];
		end else if (data_sel) begin
			rd_word = idata[way][widx]; // [RQ25]
		end
	end

	// next values of control registers and outputs
	always_comb begin
		next_ctrl      = ctrl;
		next_lock_save = lock_save;
		next_range     = sel_range;
		next_mask      = sel_mask;
		next_reload    = reload;
		next_sleep     = sleep_mode;
		next_dlock     = '0;
		next_rsp.ack   = req.valid;
		next_rsp.rdata = rd ? rd_word : 32'h00000000; // [RQ27]
		// a trap saves the auto lock state and drops it for the handler
		if (trap_entry) begin
			next_lock_save = ctrl.auto_lock; // [RQ8]
			next_ctrl.auto_lock = 2'b00;
		end
		if (wr && ctl_sp) begin
			case (req.addr)
				OFS_CACHE_BUS: begin
					next_ctrl.icache_en    = req.wdata[CB_ICACHE_EN]; // [RQ1]
					next_ctrl.icache_lock  = req.wdata[CB_ICACHE_LK]; // [RQ2]
					next_ctrl.dcache_en    = req.wdata[CB_DCACHE_EN]; // [RQ1]
					next_ctrl.dcache_lock  = req.wdata[CB_DCACHE_LK]; // [RQ2]
					next_ctrl.prefetch_en  = req.wdata[CB_PREFETCH]; // [RQ4]
					next_ctrl.wbuf_en      = req.wdata[CB_WBUF]; // [RQ3]
					next_ctrl.cacheable_en = req.wdata[CB_CACHEABLE]; // [RQ5]
					next_ctrl.nc_wait      = req.wdata[CB_NC_WAIT +: 2]; // [RQ6]
				end
				OFS_AUTO_LOCK: next_ctrl.auto_lock = req.wdata[1:0]; // [RQ7]
				OFS_LOCK_SAVE: next_lock_save = req.wdata[1:0]; // [RQ8]
				OFS_RESTORE:   next_ctrl.auto_lock = lock_save;
				OFS_BURST:     next_ctrl.burst_en = req.wdata[1:0]; // [RQ9]
				OFS_CS_ENABLE: next_ctrl.cs_en = req.wdata[NUM_CS-1:0];
				OFS_WIDTH:     next_ctrl.width_cfg = req.wdata[WIDTH_W-1:0];
				OFS_RELOAD: begin
					next_reload = req.wdata[HALF_W-1:0]; // [RQ15]
					next_ctrl.cycle_mode = req.wdata[MODE_BIT];
				end
				OFS_SLEEP: begin
					if (req.wdata[SLEEP_BIT])
						next_sleep = 1'b1; // [RQ17]
				end
				default: begin
					// the first range is hard-wired and ignores writes
					if (range_hit && sel_n != 3'd0)
						next_range[sel_n] = req.wdata[SEL_LSB +: SEL_W]; // [RQ11]
					else if (mask_hit)
						next_mask[sel_n] = req.wdata[SEL_LSB +: SEL_W]; // [RQ12]
				end
			endcase
		end
		// software sleep request beats a simultaneous wake
		if (wake && !(wr && ctl_sp && req.addr == OFS_SLEEP &&
		    req.wdata[SLEEP_BIT]))
			next_sleep = 1'b0;
		next_ctrl.cs_en[0] = 1'b1; // [RQ10]
		next_range[0] = CS0_RANGE; // [RQ11]
		if (wr && req.asi == ASI_DTAG_LOCK && local_addr < TAG_SPAN) begin
			next_dlock.strobe = 1'b1; // [RQ19]
			next_dlock.addr   = req.addr;
			next_dlock.lock   = req.wdata[TAG_LOCK];
		end
	end

	// refresh timer: a software write wins over the running count
	always_comb begin
		next_refresh = 1'b0;
		if (wr && ctl_sp && req.addr == OFS_REFRESH) begin
			next_ref_cnt = req.wdata[HALF_W-1:0]; // [RQ14]
		end else if (ref_cnt == 16'h0000) begin
			next_ref_cnt = reload; // [RQ16]
			next_refresh = 1'b1;
		end else begin
			next_ref_cnt = ref_cnt - 16'h0001;
		end
	end

	// chip select decode of the probed access
	always_comb begin
		for (int n = 0; n < NUM_CS; n++) begin
			cmp = ({probe.asi, probe.addr[31:PROBE_LSB]} ^ sel_range[n]) &
			      ~sel_mask[n]; // [RQ12]
			next_cs_hit[n] = ctrl.cs_en[n] && cmp == 30'h00000000; // [RQ11]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl          <= '0;
			ctrl.cs_en[0] <= 1'b1; // [RQ10]
			lock_save     <= 2'b00;
			reload        <= 16'h0000;
			ref_cnt       <= REFRESH_RESET; // [RQ14]
			sleep_mode    <= 1'b0; // [RQ17]
			rsp           <= '0;
			dlock_wr      <= '0;
			cs_hit        <= '0;
			refresh_req   <= 1'b0;
			for (int n = 0; n < NUM_CS; n++) begin
				sel_range[n] <= '0;
				sel_mask[n]  <= '0;
			end
			sel_range[0] <= CS0_RANGE;
			sel_mask[0]  <= CS0_MASK_RESET; // [RQ13]
		end else if (ce) begin
			ctrl        <= next_ctrl;
			lock_save   <= next_lock_save;
			reload      <= next_reload;
			ref_cnt     <= next_ref_cnt;
			sleep_mode  <= next_sleep;
			rsp         <= next_rsp;
			dlock_wr    <= next_dlock;
			cs_hit      <= next_cs_hit;
			refresh_req <= next_refresh;
			sel_range   <= next_range;
			sel_mask    <= next_mask;
		end
	end

	// valid, lock and replacement bits: a bulk clear beats a line write
	always_comb begin
		next_sbv   = tag_sbv;
		next_tlock = tag_lock;
		next_lru   = tag_lru;
		if (tag_we) begin
			next_sbv[way][idx]   = req.wdata[TAG_SBV +: 4]; // [RQ20]
			next_tlock[way][idx] = req.wdata[TAG_LOCK]; // [RQ22]
			if (!way)
				next_lru[idx] = req.wdata[TAG_LRU]; // [RQ22]
		end
		if (lock_we)
			next_tlock[way][idx] = req.wdata[TAG_LOCK]; // [RQ18]
		if (clr_valid) begin
			next_sbv[0] = '0; // [RQ24]
			next_sbv[1] = '0;
		end
		if (clr_lock) begin
			next_tlock[0] = '0; // [RQ23]
			next_tlock[1] = '0;
			next_lru      = '0;
		end
	end

	// these bits need a reset, unlike the tag address and data words
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tag_sbv[0]  <= '0; // [RQ20]
			tag_sbv[1]  <= '0;
			tag_lock[0] <= '0; // [RQ22]
			tag_lock[1] <= '0;
			tag_lru     <= '0;
		end else if (ce) begin
			tag_sbv  <= next_sbv;
			tag_lock <= next_tlock;
			tag_lru  <= next_lru;
		end
	end

	// tag address, supervisor bit and data words carry no reset
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (tag_we) begin
				tag_addr[way][idx] <= req.wdata[31:TAG_LSB];
				tag_sup[way][idx]  <= req.wdata[TAG_SUP]; // [RQ21]
			end
			if (data_we)
				idata[way][widx] <= req.wdata; // [RQ25]
		end
	end

endmodule // cache_bus_control_registers

/* iu_model.sv */
module iu_model (
	input  wire logic                       clk_sys,
	output cache_bus_pkg::bus_req_type      req,
	input  wire cache_bus_pkg::bus_rsp_type rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import cache_bus_pkg::*;

	initial req = '0;

	// one access at a time; callers pass zeros in reserved bits
	task automatic access(input logic w, input logic [7:0] asi,
		input logic [31:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic ack);
		@(negedge clk_sys);
		req = '{valid: 1'b1, write: w, asi: asi, addr: addr, wdata: wd};
		@(negedge clk_sys);
		rd = rsp.rdata;
		ack = rsp.ack;
		// stale fields are inverted so nothing leans on held values
		req = '{valid: 1'b0, write: ~w, asi: ~asi, addr: ~addr, wdata: ~wd};
	endtask
endmodule // iu_model

/* cache_bus_control_registers_props.sv */
module cache_bus_checker #(
	parameter int          LINES        = 128,
	parameter int          LINE_BYTES   = 32,
	parameter logic [31:0] INVAL_OFFSET = cache_bus_pkg::OFS_INVAL_STD,
	parameter logic [15:0] PART_VERSION = 16'h005A // arbitrary code
) (
	input wire logic                        clk_sys,
	input wire logic                        rst_n,
	input wire logic                        ce,
	input wire cache_bus_pkg::bus_req_type  req,
	input wire cache_bus_pkg::probe_type    probe,
	input wire logic                        trap_entry,
	input wire logic                        wake,
	input wire cache_bus_pkg::bus_rsp_type  rsp,
	input wire cache_bus_pkg::ctrl_out_type ctrl,
	input wire logic [5:0]                  cs_hit,
	input wire cache_bus_pkg::dlock_wr_type dlock_wr,
	input wire logic                        refresh_req,
	input wire logic                        sleep_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	import cache_bus_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	logic st;
	logic ld;
	assign st = ce && req.valid && req.write && req.asi == ASI_CONTROL;
	assign ld = ce && req.valid && !req.write && req.asi == ASI_CONTROL;

	cs0_on_a:
	assert property (ctrl.cs_en[0]) else $error("first select off");
	reset_clear_a:
	assert property ($rose(rst_n) |-> ctrl[43:31] == 13'h0 && !sleep_mode)
		else $error("control bits not cleared by reset");
	cache_ctl_a:
	assert property (st && req.addr == OFS_CACHE_BUS |=>
		{ctrl.nc_wait, ctrl.cacheable_en, ctrl.wbuf_en, ctrl.prefetch_en,
		ctrl.dcache_lock, ctrl.dcache_en, ctrl.icache_lock, ctrl.icache_en}
		== {$past(req.wdata[9:7]), $past(req.wdata[5:0])})
		else $error("cache control fields wrong after store");
	auto_lock_a:
	assert property (st && req.addr == OFS_AUTO_LOCK |=>
		ctrl.auto_lock == $past(req.wdata[1:0])) else $error("auto lock");
	trap_save_a:
	assert property (ce && trap_entry && !req.valid |=> ctrl.auto_lock == 0)
		else $error("auto lock kept on trap entry");
	burst_a:
	assert property (st && req.addr == OFS_BURST |=>
		ctrl.burst_en == $past(req.wdata[1:0])) else $error("burst enables");
	sleep_set_a:
	assert property (st && req.addr == OFS_SLEEP && req.wdata[0] |=>
		sleep_mode) else $error("sleep not entered");
	wo_read_a:
	assert property (ld && (req.addr == OFS_SLEEP || req.addr == OFS_RESTORE)
		|=> rsp.ack && rsp.rdata == 32'h0) else $error("write-only read");
	dlock_a:
	assert property (ce && req.valid && req.write && req.asi == ASI_DTAG_LOCK
		&& req.addr[30:0] < LINES * LINE_BYTES |=> dlock_wr.strobe &&
		dlock_wr.addr == $past(req.addr) && dlock_wr.lock == $past(req.wdata[0]))
		else $error("data lock write not forwarded");

	refresh_c: cover property (refresh_req);
	hit_c: cover property (cs_hit[1]);
	dlock_c: cover property (dlock_wr.strobe);
	sleep_c: cover property ($rose(sleep_mode));
endmodule // cache_bus_checker

bind cache_bus_control_registers cache_bus_checker #(
	.LINES(LINES), .LINE_BYTES(LINE_BYTES),
	.INVAL_OFFSET(INVAL_OFFSET), .PART_VERSION(PART_VERSION)
) checker_u (.clk_sys, .rst_n, .ce, .req, .probe, .trap_entry, .wake,
	.rsp, .ctrl, .cs_hit, .dlock_wr, .refresh_req, .sleep_mode);

/* tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cache_bus_pkg::*;

	logic         clk_sys = 1'b0;
	logic         rst_n = 1'b0;
	logic         ce = 1'b1;
	logic         trap_entry = 1'b0;
	logic         wake = 1'b0;
	probe_type    probe = '0;
	bus_req_type  req;
	bus_rsp_type  rsp;
	ctrl_out_type ctrl;
	logic [5:0]   cs_hit;
	dlock_wr_type dlock_wr;
	logic         refresh_req;
	logic         sleep_mode;
	int           num_errors = 0;
	int           checks_done = 0;
	int           cycles = 0;
	int           n;
	logic [31:0]  rd;
	logic         ak;

	localparam logic [31:0] SEL_FIELD = 32'h7FFFFFFE;

	always #2 clk_sys = ~clk_sys;

	cache_bus_control_registers dut_u (.clk_sys, .rst_n, .ce, .req, .probe,
		.trap_entry, .wake, .rsp, .ctrl, .cs_hit, .dlock_wr, .refresh_req,
		.sleep_mode);
	iu_model iu_u (.clk_sys, .req, .rsp);

	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] ad,
		input logic [31:0] d);
		iu_u.access(1'b1, a, ad, d, rd, ak);
	endtask

	// read data is masked so reserved and undefined bits are not judged
	task automatic rdchk(input logic [7:0] a, input logic [31:0] ad,
		input logic [31:0] m, input logic [31:0] e);
		iu_u.access(1'b0, a, ad, 32'h0, rd, ak);
		check({ak, rd & m}, {1'b1, e});
	endtask

	// cs_hit is registered, so it is looked at one cycle after the probe
	task automatic look(input logic [7:0] a, input logic [31:0] ad);
		probe = '{asi: a, addr: ad};
		@(negedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		rdchk(ASI_CONTROL, OFS_REFRESH, 32'hFFFF, 32'hFFFE);
		rdchk(ASI_CONTROL, OFS_CACHE_BUS, 32'h3F, 32'h0);
		rdchk(ASI_CONTROL, OFS_BURST, 32'h3, 32'h0);
		for (int b = 0; b < 6; b++) begin
			wr(ASI_CONTROL, OFS_CACHE_BUS, 32'h1 << b);
			check(33'(ctrl[43:38]), 33'h20 >> b);
			rdchk(ASI_CONTROL, OFS_CACHE_BUS, 32'h3F, 32'h1 << b);
		end
		wr(ASI_CONTROL, OFS_CACHE_BUS, 32'h380);
		check(33'({ctrl.cacheable_en, ctrl.nc_wait}), 33'h7);
		wr(ASI_CONTROL, OFS_AUTO_LOCK, 32'h3);
		check(33'(ctrl.auto_lock), 33'h3);
		trap_entry = 1'b1;
		@(negedge clk_sys);
		trap_entry = 1'b0;
		check(33'(ctrl.auto_lock), 33'h0);
		rdchk(ASI_CONTROL, OFS_LOCK_SAVE, 32'h3, 32'h3);
		wr(ASI_CONTROL, OFS_RESTORE, 32'h0);
		check(33'(ctrl.auto_lock), 33'h3);
		wr(ASI_CONTROL, OFS_BURST, 32'h2);
		rdchk(ASI_CONTROL, OFS_BURST, 32'h3, 32'h2);
		wr(ASI_CONTROL, OFS_CS_ENABLE, 32'h0);
		check(33'(ctrl.cs_en), 33'h01);
		wr(ASI_CONTROL, OFS_CS_ENABLE, 32'h3E);
		rdchk(ASI_CONTROL, OFS_CS_ENABLE, 32'h3F, 32'h3F);
		wr(ASI_CONTROL, OFS_RANGE_BASE + 4, 32'h10000008);
		wr(ASI_CONTROL, OFS_MASK_BASE + 4, 32'h0);
		rdchk(ASI_CONTROL, OFS_RANGE_BASE + 4, SEL_FIELD,
			32'h10000008);
		wr(ASI_CONTROL, OFS_RANGE_BASE, SEL_FIELD);
		rdchk(ASI_CONTROL, OFS_RANGE_BASE, SEL_FIELD, 32'h04800000);
		rdchk(ASI_CONTROL, OFS_MASK_BASE, SEL_FIELD, 32'h0000003E);
		look(8'h20, 32'h1000);
		check(33'(cs_hit[1]), 33'h1);
		look(8'h20, 32'h1400);
		check(33'(cs_hit[1]), 33'h0);
		look(8'h21, 32'h1000);
		check(33'(cs_hit[1]), 33'h0);
		wr(ASI_CONTROL, OFS_MASK_BASE + 4, 32'h2);
		look(8'h20, 32'h1400);
		check(33'(cs_hit[1]), 33'h1);
		look(8'h09, 32'h7C00);
		check(33'(cs_hit[0]), 33'h1);
		look(8'h09, 32'h8000);
		check(33'(cs_hit[0]), 33'h0);
		wr(ASI_CONTROL, OFS_SLEEP, 32'h1);
		check(33'(sleep_mode), 33'h1);
		rdchk(ASI_CONTROL, OFS_SLEEP, 32'hFFFFFFFF, 32'h0);
		rdchk(ASI_CONTROL, OFS_RESTORE, 32'hFFFFFFFF, 32'h0);
		check(33'({sleep_mode, ctrl.auto_lock}), 33'h7);
		ce = 1'b0;
		wake = 1'b1;
		repeat (2) @(negedge clk_sys);
		check(33'(sleep_mode), 33'h1);
		ce = 1'b1;
		@(negedge clk_sys);
		wake = 1'b0;
		check(33'(sleep_mode), 33'h0);
		wr(ASI_DTAG_LOCK, 32'h80000020, 32'h1);
		check(33'({dlock_wr.strobe, dlock_wr.lock}), 33'h3);
		check(33'(dlock_wr.addr), 33'h80000020);
		wr(ASI_ITAG, 32'h20, 32'hABCDE3E3);
		rdchk(ASI_ITAG, 32'h20, 32'hFFFFF3E3, 32'hABCDE3E3);
		wr(ASI_ITAG, 32'h80000020, 32'hABCDE3E3);
		rdchk(ASI_ITAG, 32'h80000020, 32'hFFFFF3E3, 32'hABCDE3E1);
		wr(ASI_ITAG_LOCK, 32'h20, 32'h0);
		rdchk(ASI_ITAG, 32'h20, 32'h1, 32'h0);
		wr(ASI_ITAG_LOCK, 32'h20, 32'h1);
		rdchk(ASI_ITAG, 32'h20, 32'h1, 32'h1);
		wr(ASI_ITAG, OFS_INVAL_STD, 32'h1);
		rdchk(ASI_ITAG, 32'h20, 32'h3C3, 32'h3);
		wr(ASI_ITAG, OFS_INVAL_STD, 32'h2);
		rdchk(ASI_ITAG, 32'h20, 32'h3, 32'h0);
		wr(ASI_IDATA, 32'h8, 32'h12345678);
		wr(ASI_IDATA, 32'h8000000C, 32'h9ABCDEF0);
		rdchk(ASI_IDATA, 32'h8, 32'hFFFFFFFF, 32'h12345678);
		rdchk(ASI_IDATA, 32'h8000000C, 32'hFFFFFFFF, 32'h9ABCDEF0);
		wr(ASI_CONTROL, OFS_RELOAD, 32'h80000003);
		rdchk(ASI_CONTROL, OFS_RELOAD, 32'h8000FFFF, 32'h80000003);
		check(33'(ctrl.cycle_mode), 33'h1);
		wr(ASI_CONTROL, OFS_REFRESH, 32'h100);
		rdchk(ASI_CONTROL, OFS_REFRESH, 32'hFFFF, 32'hFF);
		n = 0;
		while (refresh_req !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (refresh_req !== 1'b1 && n < 20);
		check(33'(n), 33'd4);
		complete_run();
	end
endmodule // tb_top
